// ===== core/ranging_code_generator.sv
// What this block does
// - Code advance counts second-component clocks beyond an all-ones start.
// - Listed initial state is first 13 second-component chips, LSB first.
// - First 13 output chips equal complement of listed initial state.
// - A PRN selects in-phase and quadrature phases together, never mixed.
// - Lookup holds PRNs 38 to 63 with both advances and states.
// - Supported PRNs 38 to 63 must use exactly the assigned phases.
// - In-phase train is code XOR navigation symbols XOR in-phase sync.
// - Quadrature train is code XOR its own sync, no navigation data.
// - Codes, sync, data timing and carrier controls share one reference.
// - Both codes chip at the 10.23 MHz reference rate.
// - In-phase one reverses in-phase carrier; zero keeps reference phase.
// - Quadrature one advances carrier 90 degrees, zero keeps reference phase.
// - Quadrature carrier lags in-phase carrier by 90 degrees.
// - Each spreading code is first-component XOR second-component code.
// - 50 bps data rate-half encoded to 100 sps, on in-phase only.
// - In-phase sync is a 10-bit code at 1 kHz over the symbols.
// - Quadrature sync is a 20-bit code at 1 kHz.
`timescale 1ns/100ps
module ranging_code_generator
    import ranging_code_pkg::*;
#(
    parameter logic [NCO_WIDTH-1:0] CHIP_STEP = NCO_WIDTH'(CHIP_STEP_WIDE)
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    // Control
    input  wire logic                 restart,
    input  wire logic [PRN_WIDTH-1:0] prn_select,
    output logic                      running,
    output logic                      prn_error,
    output logic [CODE_WIDTH-1:0]     i_advance,
    output logic [CODE_WIDTH-1:0]     q_advance,
    // Navigation data
    input  wire logic                 nav_bit,
    output logic                      nav_bit_take,
    // Chip streams
    output logic                      chip_strobe,
    output logic                      epoch_strobe,
    output logic                      in_phase_spreading_code,
    output logic                      quadrature_spreading_code,
    output logic                      in_phase_train,
    output logic                      quadrature_train,
    // Carrier control
    output logic                      i_carrier_flip,
    output logic                      q_carrier_advance,
    output logic [1:0]                carrier_phase
);

    function automatic prn_entry_t prn_entry(input logic [PRN_WIDTH-1:0] p);
        unique case (p)
            6'h26: prn_entry = {13'h14EE, 13'h1082, 13'h0B06, 13'h1F9D};
            6'h27: prn_entry = {13'h0DDE, 13'h15E4, 13'h1265, 13'h0A9F};
            6'h28: prn_entry = {13'h0D54, 13'h18E7, 13'h19CA, 13'h11AA};
            6'h29: prn_entry = {13'h0333, 13'h0BF0, 13'h0ED9, 13'h05E4};
            6'h2A: prn_entry = {13'h1200, 13'h06EC, 13'h076C, 13'h1620};
            6'h2B: prn_entry = {13'h0E72, 13'h0E4E, 13'h06FA, 13'h0659};
            6'h2C: prn_entry = {13'h03C2, 13'h1131, 13'h12D1, 13'h1128};
            6'h2D: prn_entry = {13'h0BB9, 13'h1462, 13'h12BF, 13'h007E};
            6'h2E: prn_entry = {13'h1159, 13'h0B16, 13'h0E3D, 13'h0013};
            6'h2F: prn_entry = {13'h1349, 13'h1B01, 13'h0044, 13'h0B9E};
            6'h30: prn_entry = {13'h0E85, 13'h0695, 13'h1151, 13'h0247};
            6'h31: prn_entry = {13'h127A, 13'h04AA, 13'h0689, 13'h0784};
            6'h32: prn_entry = {13'h1C7B, 13'h1B33, 13'h11F1, 13'h095C};
            6'h33: prn_entry = {13'h08E7, 13'h1389, 13'h1729, 13'h051F};
            6'h34: prn_entry = {13'h1DBD, 13'h1A26, 13'h095A, 13'h1B99};
            6'h35: prn_entry = {13'h165B, 13'h03DF, 13'h0042, 13'h07EF};
            6'h36: prn_entry = {13'h1B76, 13'h1D41, 13'h0C6E, 13'h1937};
            6'h37: prn_entry = {13'h05C3, 13'h0989, 13'h00CE, 13'h1266};
            6'h38: prn_entry = {13'h0A21, 13'h027F, 13'h1DDE, 13'h0899};
            6'h39: prn_entry = {13'h0B58, 13'h0831, 13'h0213, 13'h000B};
            6'h3A: prn_entry = {13'h0808, 13'h09C2, 13'h00A1, 13'h006F};
            6'h3B: prn_entry = {13'h0AC5, 13'h1946, 13'h0861, 13'h0B6F};
            6'h3C: prn_entry = {13'h0EAC, 13'h095F, 13'h0949, 13'h090D};
            6'h3D: prn_entry = {13'h183D, 13'h00F2, 13'h079E, 13'h1B2B};
            6'h3E: prn_entry = {13'h13BD, 13'h0EB8, 13'h1631, 13'h15C4};
            6'h3F: prn_entry = {13'h1925, 13'h04A2, 13'h0BCB, 13'h0469};
            default: prn_entry = '0;
        endcase
    endfunction : prn_entry

    run_state_t                state;
    logic [PRN_WIDTH-1:0]      prn_held;
    logic [NCO_WIDTH-1:0]      nco_acc;
    logic                      chip_tick;
    logic [CHIP_CNT_WIDTH-1:0] chip_cnt;
    logic [CONV_HIST-1:0]      conv_hist;
    logic [1:0]                sym_pair;
    logic                      sym_second;

    // Table selection: one index feeds both halves of the pair
    wire prn_entry_t sel_entry  = prn_entry(prn_select);
    wire prn_entry_t held_entry = prn_entry(prn_held);
    wire logic       prn_ok     = (prn_select >= PRN_FIRST)
                                && (prn_select <= PRN_LAST);
    wire logic       start      = restart && prn_ok;
    wire logic       is_run     = (state == RUN);

    // Chip timing from the single system clock
    wire logic [NCO_WIDTH:0] nco_sum = {1'b0, nco_acc} + {1'b0, CHIP_STEP};
    wire logic step_chip  = is_run && chip_tick;
    wire logic last_chip  = (chip_cnt == CODE_LAST);
    wire logic epoch      = step_chip && last_chip;
    wire logic xa_wrap    = step_chip && (chip_cnt == XA_SHORT_LAST);

    // Code generators
    wire logic [CODE_WIDTH-1:0] xa_state;
    wire logic [CODE_WIDTH-1:0] xbi_state;
    wire logic [CODE_WIDTH-1:0] xbq_state;
    wire logic first_component_code;
    wire logic in_phase_second_component;
    wire logic quadrature_second_component;
    wire logic xa_load   = start || epoch || xa_wrap;
    wire logic xb_load   = start || epoch;
    wire logic xb_step   = step_chip && !epoch;
    wire logic [CODE_WIDTH-1:0] i_init_val =
        start ? sel_entry.i_init : held_entry.i_init;
    wire logic [CODE_WIDTH-1:0] q_init_val =
        start ? sel_entry.q_init : held_entry.q_init;

    code_lfsr #(
        .WIDTH      (CODE_WIDTH),
        .TAPS       (XA_TAPS)
    ) u_first_component (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .load       (xa_load),
        .load_value (CODE_ALL_ONES),
        .step       (xb_step),
        .state      (xa_state),
        .chip       (first_component_code)
    );

    code_lfsr #(
        .WIDTH      (CODE_WIDTH),
        .TAPS       (XB_TAPS)
    ) u_in_phase_second (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .load       (xb_load),
        .load_value (i_init_val),
        .step       (xb_step),
        .state      (xbi_state),
        .chip       (in_phase_second_component)
    );

    code_lfsr #(
        .WIDTH      (CODE_WIDTH),
        .TAPS       (XB_TAPS)
    ) u_quadrature_second (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .load       (xb_load),
        .load_value (q_init_val),
        .step       (xb_step),
        .state      (xbq_state),
        .chip       (quadrature_second_component)
    );

    // Sync sequences advance once per code epoch
    wire logic nh_in_bit;
    wire logic nh_in_wrap;
    wire logic nh_q_bit;

    sync_sequence #(
        .LEN     (NH_IN_LEN),
        .PATTERN (NH_IN_PATTERN)
    ) u_nh_in_phase (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (start),
        .step    (epoch),
        .seq_bit (nh_in_bit),
        .wrap    (nh_in_wrap)
    );

    sync_sequence #(
        .LEN     (NH_Q_LEN),
        .PATTERN (NH_Q_PATTERN)
    ) u_nh_quadrature (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (start),
        .step    (epoch),
        .seq_bit (nh_q_bit),
        .wrap    ()
    );

    // Encoder: one data bit yields two symbols, G1 sent first
    wire logic sym_edge   = epoch && nh_in_wrap;
    wire logic take_bit   = start || (sym_edge && sym_second);
    wire logic [CONV_HIST:0] conv_win = {nav_bit, conv_hist};
    wire logic [1:0] next_sym_pair = {^(conv_win & CONV_G1),
                                      ^(conv_win & CONV_G2)};
    wire logic navigation_symbol_stream =
        sym_second ? sym_pair[0] : sym_pair[1];

    // Chip combination
    wire logic i_code = first_component_code
                      ^ in_phase_second_component;
    wire logic q_code = first_component_code
                      ^ quadrature_second_component;
    wire logic next_i_train = is_run && (i_code
                            ^ navigation_symbol_stream
                            ^ nh_in_bit);
    wire logic next_q_train = is_run && (q_code ^ nh_q_bit);
    wire logic [1:0] next_phase =
        ({next_i_train, next_q_train} == 2'h0) ? PHASE_ZERO :
        ({next_i_train, next_q_train} == 2'h2) ? PHASE_LAG_90 :
        ({next_i_train, next_q_train} == 2'h1) ? PHASE_LEAD_90 :
        PHASE_HALF;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= HALT;
            prn_held  <= PRN_FIRST;
            prn_error <= 1'b0;
        end else if (restart) begin
            state     <= prn_ok ? RUN : HALT;
            prn_held  <= prn_ok ? prn_select : prn_held;
            prn_error <= !prn_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            i_advance <= '0;
            q_advance <= '0;
        end else if (start) begin
            i_advance <= sel_entry.i_advance;
            q_advance <= sel_entry.q_advance;
        end
    end

    // Restart realigns the chip phase so every element starts together
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            nco_acc   <= '0;
            chip_tick <= 1'b0;
        end else begin
            nco_acc   <= start ? '0 : nco_sum[NCO_WIDTH-1:0];
            chip_tick <= !start && nco_sum[NCO_WIDTH];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            chip_cnt <= CHIP_CNT_ZERO;
        end else if (start || epoch) begin
            chip_cnt <= CHIP_CNT_ZERO;
        end else if (step_chip) begin
            chip_cnt <= CHIP_CNT_WIDTH'(chip_cnt + CHIP_CNT_ONE);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_hist  <= '0;
            sym_pair   <= 2'h0;
            sym_second <= 1'b0;
        end else if (take_bit) begin
            conv_hist  <= conv_win[CONV_HIST:1];
            sym_pair   <= next_sym_pair;
            sym_second <= 1'b0;
        end else if (sym_edge) begin
            sym_second <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            running                   <= 1'b0;
            nav_bit_take              <= 1'b0;
            chip_strobe               <= 1'b0;
            epoch_strobe              <= 1'b0;
            in_phase_spreading_code   <= 1'b0;
            quadrature_spreading_code <= 1'b0;
            in_phase_train            <= 1'b0;
            quadrature_train          <= 1'b0;
            i_carrier_flip            <= 1'b0;
            q_carrier_advance         <= 1'b0;
            carrier_phase             <= PHASE_ZERO;
        end else begin
            running                   <= is_run;
            nav_bit_take              <= take_bit;
            chip_strobe               <= step_chip;
            epoch_strobe              <= epoch;
            in_phase_spreading_code   <= is_run && i_code;
            quadrature_spreading_code <= is_run && q_code;
            in_phase_train            <= next_i_train;
            quadrature_train          <= next_q_train;
            i_carrier_flip            <= next_i_train;
            q_carrier_advance         <= next_q_train;
            carrier_phase             <= next_phase;
        end
    end

    // Checks
    localparam int CHIP_GAP_MAX = 20;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_started;
        start ##1 is_run;
    endsequence

    sequence s_epoch_reload;
        epoch ##1 (xbi_state == held_entry.i_init)
              && (xbq_state == held_entry.q_init)
              && (xa_state == CODE_ALL_ONES);
    endsequence

    epoch_reload_a : assert property (epoch |-> s_epoch_reload)
        else $error("second-component state not reloaded at epoch");

    first_chips_a : assert property (s_started |->
        (i_code == !held_entry.i_init[0])
        && (q_code == !held_entry.q_init[0]))
        else $error("first chip is not complement of initial state");

    pair_match_a : assert property (start |=>
        (xbi_state == $past(sel_entry.i_init))
        && (xbq_state == $past(sel_entry.q_init))
        && (i_advance == $past(sel_entry.i_advance))
        && (q_advance == $past(sel_entry.q_advance)))
        else $error("in-phase and quadrature phases not from one PRN");

    lut_example_a : assert property (
        (start && (prn_select == PRN_FIRST)) |=>
        (i_advance == 13'h14EE) && (q_advance == 13'h1082))
        else $error("first table entry advances wrong");

    in_train_a : assert property (##1 in_phase_train ==
        $past(is_run && (i_code ^ navigation_symbol_stream ^ nh_in_bit)))
        else $error("in-phase train mismatch");

    q_train_a : assert property (##1 quadrature_train ==
        $past(is_run && (q_code ^ nh_q_bit)))
        else $error("quadrature train mismatch");

    chip_gap_a : assert property (
        chip_tick |=> !chip_tick ##[0:CHIP_GAP_MAX] (chip_tick || start))
        else $error("chip tick spacing outside reference rate");

    phase_map_a : assert property (
        (i_carrier_flip == in_phase_train)
        && (q_carrier_advance == quadrature_train)
        && ((carrier_phase == PHASE_LAG_90)
            == (in_phase_train && !quadrature_train)))
        else $error("carrier phase does not follow code state");

    xa_short_a : assert property (xa_wrap |=>
        (xa_state == CODE_ALL_ONES) && (chip_cnt == XA_SHORT_LAST + 1'b1))
        else $error("first-component code not short-cycled");

    sym_take_a : assert property (
        (sym_edge && sym_second) |=> nav_bit_take && !sym_second)
        else $error("navigation bit not taken after two symbols");

    bad_prn_a : assert property (
        (restart && !prn_ok) |=> prn_error && !is_run ##1 !running)
        else $error("unsupported PRN not flagged");

endmodule : ranging_code_generator

// ===== core/ranging_code_pkg.sv
package ranging_code_pkg;

    // Code register geometry and sequence lengths
    localparam int              CODE_WIDTH     = 13;
    localparam int              CHIP_CNT_WIDTH = 14;
    localparam logic [12:0]     CODE_ALL_ONES  = 13'h1FFF;
    localparam logic [13:0]     CODE_LAST      = 14'h27F5;
    localparam logic [13:0]     XA_SHORT_LAST  = 14'h1FFD;
    localparam logic [13:0]     CHIP_CNT_ZERO  = 14'h0000;
    localparam logic [13:0]     CHIP_CNT_ONE   = 14'h0001;

    // Feedback taps, bit k holds the chip k places ahead of the output
    localparam logic [12:0]     XA_TAPS        = 13'h1601;
    localparam logic [12:0]     XB_TAPS        = 13'h11DB;

    // Synchronisation sequences, first bit in the MSB
    localparam int              NH_IN_LEN      = 10;
    localparam logic [9:0]      NH_IN_PATTERN  = 10'h035;
    localparam int              NH_Q_LEN       = 20;
    localparam logic [19:0]     NH_Q_PATTERN   = 20'h04D4E;

    // Rate one-half encoder, constraint length seven
    localparam int              CONV_HIST      = 6;
    localparam logic [6:0]      CONV_G1        = 7'h79;
    localparam logic [6:0]      CONV_G2        = 7'h5B;

    // Supported table span
    localparam int              PRN_WIDTH      = 6;
    localparam logic [5:0]      PRN_FIRST      = 6'h26;
    localparam logic [5:0]      PRN_LAST       = 6'h3F;

    // Clock and chip rate
    localparam longint          CLOCK_HZ       = 200_000_000;
    localparam longint          CHIP_RATE_HZ   = 10_230_000;
    localparam int              NCO_WIDTH      = 32;
    localparam longint          CHIP_STEP_WIDE =
        (CHIP_RATE_HZ * (64'h1 << NCO_WIDTH) + CLOCK_HZ / 2) / CLOCK_HZ;

    // Composite carrier phase in quarter turns, positive leads
    localparam logic [1:0]      PHASE_ZERO     = 2'h0;
    localparam logic [1:0]      PHASE_LEAD_90  = 2'h1;
    localparam logic [1:0]      PHASE_HALF     = 2'h2;
    localparam logic [1:0]      PHASE_LAG_90   = 2'h3;

    typedef struct packed {
        logic [12:0] i_advance;
        logic [12:0] q_advance;
        logic [12:0] i_init;
        logic [12:0] q_init;
    } prn_entry_t;

    typedef enum logic {HALT, RUN} run_state_t;

endpackage : ranging_code_pkg

// ===== core/code_lfsr.sv
`timescale 1ns/100ps
module code_lfsr
    import ranging_code_pkg::*;
#(
    parameter int                WIDTH = CODE_WIDTH,
    parameter logic [WIDTH-1:0]  TAPS  = XB_TAPS
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             step,
    // Code
    output logic      [WIDTH-1:0] state,
    output logic                  chip
);

    wire logic feedback = ^(state & TAPS);

    assign chip = state[0];

    // Output is stage zero, so a loaded pattern leaves LSB first
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= CODE_ALL_ONES;
        end else if (load) begin
            state <= load_value;
        end else if (step) begin
            state <= {feedback, state[WIDTH-1:1]};
        end
    end

endmodule : code_lfsr

// ===== core/sync_sequence.sv
`timescale 1ns/100ps
module sync_sequence
    import ranging_code_pkg::*;
#(
    parameter int              LEN     = NH_IN_LEN,
    parameter logic [LEN-1:0]  PATTERN = NH_IN_PATTERN
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // Control
    input  wire logic load,
    input  wire logic step,
    // Sequence
    output logic      seq_bit,
    output logic      wrap
);

    localparam int IW = $clog2(LEN);
    localparam logic [IW-1:0] IDX_LAST = IW'(LEN - 1);
    localparam logic [IW-1:0] IDX_ZERO = '0;

    logic [IW-1:0] idx;

    wire logic [IW-1:0] bit_pos = IDX_LAST - idx;

    assign seq_bit = PATTERN[bit_pos];
    assign wrap    = (idx == IDX_LAST);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx <= IDX_ZERO;
        end else if (load) begin
            idx <= IDX_ZERO;
        end else if (step) begin
            idx <= wrap ? IDX_ZERO : IW'(idx + 1'b1);
        end
    end

endmodule : sync_sequence

// ===== testbench/carrier_partner.sv
`timescale 1ns/100ps
module carrier_partner (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Navigation data
    input  wire logic        nav_bit_take,
    output logic             nav_bit,
    // Carrier control seen at the modulator
    input  wire logic        i_carrier_flip,
    input  wire logic        q_carrier_advance,
    output logic [1:0]       phase_seen
);
    // Composite phase in quarter turns: I and Q reversed together is half a turn
    assign phase_seen = {i_carrier_flip,
                         i_carrier_flip ^ q_carrier_advance};

    // A bit stays put until the generator says it took it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            nav_bit <= 1'b1;
        end else if (nav_bit_take) begin
            nav_bit <= 1'($urandom);
        end
    end
endmodule : carrier_partner

// ===== testbench/tb_ranging_code_generator.sv
`timescale 1ns/100ps
module tb_ranging_code_generator
    import ranging_code_pkg::*;
;
    localparam logic [31:0] FAST_STEP = 32'h4000_0000;
    localparam int ADV_I [26] = '{5358, 3550, 3412, 819, 4608, 3698, 962,
        3001, 4441, 4937, 3717, 4730, 7291, 2279, 7613, 5723, 7030, 1475,
        2593, 2904, 2056, 2757, 3756, 6205, 5053, 6437};
    localparam int ADV_Q [26] = '{4226, 5604, 6375, 3056, 1772, 3662, 4401,
        5218, 2838, 6913, 1685, 1194, 6963, 5001, 6694, 991, 7489, 2441,
        639, 2097, 2498, 6470, 2399, 242, 3768, 1186};

    logic              sys_clk    = 1'b0;
    logic              rst_b      = 1'b0;
    logic              restart    = 1'b0;
    logic [5:0]        prn_select = 6'h26;
    logic              nav_bit, running, prn_error, nav_bit_take;
    logic              chip_strobe, epoch_strobe, i_carrier_flip;
    logic              in_phase_spreading_code, quadrature_spreading_code;
    logic              in_phase_train, quadrature_train, q_carrier_advance;
    logic [12:0]       i_advance, q_advance;
    logic [1:0]        carrier_phase, phase_seen;
    logic [12:0]       exp_i      = 13'h0000;
    logic [12:0]       exp_q      = 13'h0000;
    logic              sym;
    int                n_fail     = 0;
    int                n_checks   = 0;

    ranging_code_generator #(.CHIP_STEP(FAST_STEP)) ranging_code_generator_i (
        .sys_clk, .rst_b, .restart, .prn_select, .running, .prn_error,
        .i_advance, .q_advance, .nav_bit, .nav_bit_take, .chip_strobe,
        .epoch_strobe, .in_phase_spreading_code, .quadrature_spreading_code,
        .in_phase_train, .quadrature_train, .i_carrier_flip,
        .q_carrier_advance, .carrier_phase
    );

    carrier_partner carrier_partner_i (
        .sys_clk, .rst_b, .nav_bit_take, .nav_bit, .i_carrier_flip,
        .q_carrier_advance, .phase_seen
    );

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [15:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Pulse restart for one edge; the answer stands just after that edge
    task automatic start(input logic [5:0] p);
        @(posedge sys_clk);
        restart    <= 1'b1;
        prn_select <= p;
        @(posedge sys_clk);
        restart <= 1'b0;
        sym = nav_bit;
        #1;
        if (p >= PRN_FIRST) begin
            exp_i = 13'(ADV_I[p - PRN_FIRST]);
            exp_q = 13'(ADV_Q[p - PRN_FIRST]);
        end
        check("prn_error", 13'(p < PRN_FIRST), prn_error);
        check("nav take", 13'(p >= PRN_FIRST), nav_bit_take);
        check("i_advance", exp_i, i_advance);
        check("q_advance", exp_q, q_advance);
    endtask : start

    task automatic halted();
        check("running", 1'b0, running);
        check("i train", 1'b0, in_phase_train);
        check("q train", 1'b0, quadrature_train);
        check("phase", 2'h0, carrier_phase);
    endtask : halted

    // First 13 chips after a restart against the listed initial states
    task automatic chips(input logic [12:0] si, sq, input logic first);
        int   gap;
        logic x;
        tick(1);
        check("running", 1'b1, running);
        x = in_phase_train ^ in_phase_spreading_code;
        if (first) check("symbol", sym, x);
        for (int k = 0; k < 13; k++) begin
            if (k > 0) begin
                gap = 1;
                do begin
                    tick(1);
                    gap++;
                end while (chip_strobe !== 1'b1 && gap < 30);
                // The new chip shows one cycle after its strobe
                tick(1);
                if (k > 1) check("chip gap", 13'h0004, 13'(gap));
            end
            check("i code", !si[k], in_phase_spreading_code);
            check("q code", !sq[k], quadrature_spreading_code);
            check("i train", x, in_phase_train ^ in_phase_spreading_code);
            check("q train", quadrature_spreading_code, quadrature_train);
            check("i flip", in_phase_train, i_carrier_flip);
            check("q shift", quadrature_train, q_carrier_advance);
            check("phase", phase_seen, carrier_phase);
            check("epoch", 1'b0, epoch_strobe);
        end
    endtask : chips

    initial begin
        logic [5:0] p;
        int         n;
        void'($urandom(28));
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        tick(1);
        halted();
        check("i_advance", 13'h0000, i_advance);
        start(6'h26);
        chips(13'h0B06, 13'h1F9D, 1'b1);
        start(6'h3F);
        chips(13'h0BCB, 13'h0469, 1'b0);
        start(6'h2E);
        chips(13'h0E3D, 13'h0013, 1'b0);
        start(6'h39);
        chips(13'h0213, 13'h000B, 1'b0);
        // Back to back: the later selection wins and restarts from chip 0
        @(posedge sys_clk);
        restart    <= 1'b1;
        prn_select <= 6'h30;
        start(6'h26);
        chips(13'h0B06, 13'h1F9D, 1'b0);
        repeat (24) begin
            p = 6'($urandom_range(63, 20));
            start(p);
            tick(3);
            if (p < PRN_FIRST) halted();
            else check("running", 1'b1, running);
        end
        start(6'h25);
        tick(3);
        halted();
        // One code period: 10230 chips of four cycles, the first chip one cycle longer
        start(6'h26);
        n = 0;
        while (epoch_strobe !== 1'b1 && n < 41000) begin
            tick(1);
            n++;
        end
        check("epoch cycles", 16'(40921), 16'(n));
        chips(13'h0B06, 13'h1F9D, 1'b0);
        // Reset in mid-run clears everything at once
        @(posedge sys_clk);
        rst_b <= 1'b0;
        tick(1);
        halted();
        check("q_advance", 13'h0000, q_advance);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        tick(1);
        halted();
        start(6'h3F);
        chips(13'h0BCB, 13'h0469, 1'b1);
        end_of_test();
    end

    // The tests take about forty-one thousand cycles, mostly one epoch
    initial begin
        #(60000 * 5);
        n_fail++;
        end_of_test();
    end
endmodule : tb_ranging_code_generator
